// File: core/dcmfs_timer.v
`timescale 1ns/10ps
`default_nettype none

// Retriggerable down counter: busy while counting after the last trigger.
module dcmfs_timer #(
   parameter [31:0] LOAD = 32'h00000010
) (
   input  wire        clock_i,
   input  wire        reset_i,
   input  wire        trig_i,
   output wire        busy_o
);

   reg [31:0] count_r;

   // A trigger reloads; otherwise count down to zero.
   always @(posedge clock_i) begin
      if (reset_i) begin
         count_r <= 32'h00000000;
      end else if (trig_i) begin
         count_r <= LOAD;
      end else if (count_r != 32'h00000000) begin
         count_r <= count_r - 32'h00000001;
      end
   end

   assign busy_o = trig_i | (count_r != 32'h00000000);

endmodule

`default_nettype wire

// File: core/dcmfs_top.v
// Contract
// - Stop motor on undervoltage, heat, overcurrent.
// - Stop on limit switch in travel direction.
// - Any fault shows slow red flash.
// - Supply, heat, current faults held three seconds.
// - Limit fault indication drops at once.
// - No valid command flags link error, yellow.
// - Valid command clears link error immediately.
// - Positive voltage: supply white, ground green.
// - Negative voltage: supply green, ground white.
// - No ramp: output jumps to target.
// - Ramp set: output steps toward target.
// - Report current, heat, voltage, limit flags.
// - Identifier is one after reset.
// - Indicator shows highest priority condition only.
`timescale 1ns/10ps
`default_nettype none
`include "dcmfs_regs.vh"

module dcmfs_top #(
   parameter [31:0] HOLD_CYC = `DCMFS_HOLD_CYC,
   parameter [31:0] LINK_CYC = `DCMFS_LINK_CYC,
   parameter [31:0] SLOW_CYC = `DCMFS_SLOW_CYC,
   parameter [31:0] FAST_CYC = `DCMFS_FAST_CYC
) (
   input  wire        clock_i,
   input  wire        reset_i,
   // AHB-Lite slave.
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output reg  [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // Sensors and command sources.
   input  wire        undervolt_i,
   input  wire        overtemp_i,
   input  wire        overcur_i,
   input  wire        limit_fwd_i,
   input  wire        limit_rev_i,
   input  wire        pwm_valid_i,
   input  wire [15:0] pwm_volt_i,
   // Bridge drive and indicator.
   output reg         white_high_o,
   output reg         white_low_o,
   output reg         green_high_o,
   output reg         green_low_o,
   output reg  [15:0] out_volt_o,
   output reg  [1:0]  led_color_o,
   output wire        irq_o
);

   localparam [1:0] ST_RUN   = 2'h0;
   localparam [1:0] ST_FAULT = 2'h1;
   localparam [1:0] ST_LINK  = 2'h2;

   reg        ctrl_en_r;
   reg [15:0] cmd_volt_r;
   reg [15:0] ramp_r;
   reg [7:0]  ident_r;
   reg [6:0]  irq_st_r;
   reg [6:0]  irq_msk_r;
   reg [15:0] target_r;
   reg [1:0]  state_r;
   reg [1:0]  state_nxt;
   reg [31:0] blink_r;
   reg [6:0]  evt_prev_r;
   reg        ap_wr_r;
   reg        ap_rd_r;
   reg [11:0] ap_addr_r;
   reg [1:0]  led_nxt;
   reg [15:0] volt_nxt;

   wire       hard_busy;
   wire       link_busy;
   wire       hard_now;
   wire       dir_fwd;
   wire       dir_rev;
   wire       lim_fault;
   wire       shutdown;
   wire       link_err;
   wire       fault_show;
   wire       cmd_valid;
   wire [6:0] events;
   wire       ap_take;
   wire       slow_on;
   wire       fast_on;
   wire [15:0] mag;

   // AHB-Lite address phase; every transfer answers with zero wait states.
   assign ap_take     = hsel_i & hready_i & htrans_i[1];
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   always @(posedge clock_i) begin
      if (reset_i) begin
         ap_wr_r   <= 1'b0;
         ap_rd_r   <= 1'b0;
         ap_addr_r <= 12'h000;
      end else begin
         ap_wr_r   <= ap_take & hwrite_i;
         ap_rd_r   <= ap_take & ~hwrite_i;
         ap_addr_r <= haddr_i[11:0];
      end
   end

   // A CAN command write counts as a valid command when the link is enabled.
   assign cmd_valid = (ap_wr_r & (ap_addr_r == `DCMFS_OFF_CMD) & ctrl_en_r) | pwm_valid_i;

   // Register writes; a status bit set by hardware wins over a clear.
   always @(posedge clock_i) begin
      if (reset_i) begin
         ctrl_en_r  <= 1'b0;
         cmd_volt_r <= 16'h0000;
         ramp_r     <= `DCMFS_RST_RAMP;
         ident_r    <= `DCMFS_RST_IDENT;
         irq_st_r   <= 7'h00;
         irq_msk_r  <= 7'h00;
      end else begin
         if (ap_wr_r) begin
            case (ap_addr_r)
               `DCMFS_OFF_CTRL:   ctrl_en_r  <= hwdata_i[`DCMFS_B_CTRL_EN];
               `DCMFS_OFF_CMD:    cmd_volt_r <= hwdata_i[15:0];
               `DCMFS_OFF_RAMP:   ramp_r     <= hwdata_i[15:0];
               `DCMFS_OFF_IDENT:  ident_r    <= hwdata_i[7:0];
               `DCMFS_OFF_IRQMSK: irq_msk_r  <= hwdata_i[6:0];
               default:           ident_r    <= ident_r;
            endcase
         end
         if (ap_wr_r && ap_addr_r == `DCMFS_OFF_IRQST) begin
            irq_st_r <= (irq_st_r & ~hwdata_i[6:0]) | events;
         end else begin
            irq_st_r <= irq_st_r | events;
         end
      end
   end

   // Read data, registered in the data phase; unmapped offsets read zero.
   always @(posedge clock_i) begin
      if (reset_i) begin
         hrdata_o <= 32'h00000000;
      end else if (ap_take && !hwrite_i) begin
         case (haddr_i[11:0])
            `DCMFS_OFF_CTRL:   hrdata_o <= {31'h00000000, ctrl_en_r};
            `DCMFS_OFF_CMD:    hrdata_o <= {16'h0000, cmd_volt_r};
            `DCMFS_OFF_RAMP:   hrdata_o <= {16'h0000, ramp_r};
            `DCMFS_OFF_IDENT:  hrdata_o <= {24'h000000, ident_r};
            `DCMFS_OFF_STATUS: hrdata_o <= {25'h0000000, fault_show, link_err, limit_rev_i,
                                            limit_fwd_i, undervolt_i, overtemp_i, overcur_i};
            `DCMFS_OFF_OUTV:   hrdata_o <= {16'h0000, out_volt_o};
            `DCMFS_OFF_IRQST:  hrdata_o <= {25'h0000000, irq_st_r};
            `DCMFS_OFF_IRQMSK: hrdata_o <= {25'h0000000, irq_msk_r};
            default:           hrdata_o <= 32'h00000000;
         endcase
      end
   end

   // Direction of travel follows the applied output or the pending target.
   // Using the target too keeps a limit fault asserted after the output has
   // been forced to zero, so the drive cannot chatter against the switch.
   assign dir_fwd = ((out_volt_o != 16'h0000) & ~out_volt_o[15]) |
                    ((target_r != 16'h0000) & ~target_r[15]);
   assign dir_rev = out_volt_o[15] | target_r[15];

   assign hard_now  = undervolt_i | overtemp_i | overcur_i;
   assign lim_fault = (limit_fwd_i & dir_fwd) | (limit_rev_i & dir_rev);
   assign shutdown  = hard_now | lim_fault;

   dcmfs_timer #(
      .LOAD    (HOLD_CYC)
   ) u_hold (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .trig_i  (hard_now),
      .busy_o  (hard_busy)
   );

   dcmfs_timer #(
      .LOAD    (LINK_CYC)
   ) u_link (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .trig_i  (cmd_valid),
      .busy_o  (link_busy)
   );

   assign link_err   = ~link_busy;
   assign fault_show = hard_busy | lim_fault;

   // Events that set sticky interrupt bits are rising edges of conditions.
   assign events = {fault_show, link_err, limit_rev_i, limit_fwd_i,
                    undervolt_i, overtemp_i, overcur_i} & ~evt_prev_r;
   assign irq_o  = |(irq_st_r & irq_msk_r);

   always @(posedge clock_i) begin
      if (reset_i) begin
         evt_prev_r  <= 7'h7F;
      end else begin
         evt_prev_r  <= {fault_show, link_err, limit_rev_i, limit_fwd_i,
                         undervolt_i, overtemp_i, overcur_i};
      end
   end

   // Target follows the active command source; PWM takes over when valid.
   always @(posedge clock_i) begin
      if (reset_i) begin
         target_r <= 16'h0000;
      end else if (pwm_valid_i) begin
         target_r <= pwm_volt_i;
      end else if (link_err) begin
         target_r <= 16'h0000;
      end else begin
         target_r <= cmd_volt_r;
      end
   end

   // Indicator state: fault outranks link loss, which outranks running.
   always @* begin
      if (fault_show) begin
         state_nxt = ST_FAULT;
      end else if (link_err) begin
         state_nxt = ST_LINK;
      end else begin
         state_nxt = ST_RUN;
      end
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         state_r <= ST_RUN;
         blink_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         blink_r <= blink_r + 32'h00000001;
      end
   end

   // Slow and fast flash phases from one free-running counter.
   assign slow_on = ((blink_r / SLOW_CYC) % 2) == 32'h00000000;
   assign fast_on = ((blink_r / FAST_CYC) % 2) == 32'h00000000;

   always @* begin
      case (state_r)
         ST_FAULT: led_nxt = slow_on ? `DCMFS_LED_RED : `DCMFS_LED_OFF;
         ST_LINK:  led_nxt = slow_on ? `DCMFS_LED_YELLOW : `DCMFS_LED_OFF;
         ST_RUN: begin
            if (out_volt_o == 16'h0000) begin
               led_nxt = `DCMFS_LED_YELLOW;
            end else if (out_volt_o[15]) begin
               led_nxt = fast_on ? `DCMFS_LED_RED : `DCMFS_LED_OFF;
            end else begin
               led_nxt = fast_on ? `DCMFS_LED_GREEN : `DCMFS_LED_OFF;
            end
         end
         default:  led_nxt = `DCMFS_LED_OFF;
      endcase
   end

   // Ramp step: signed move toward the target by at most the ramp rate.
   assign mag = ramp_r;

   always @* begin
      if (shutdown) begin
         volt_nxt = 16'h0000;
      end else if (ramp_r == 16'h0000) begin
         volt_nxt = target_r;
      end else if ($signed(target_r) > $signed(out_volt_o)) begin
         if ($signed(target_r) - $signed(out_volt_o) > $signed({1'b0, mag}))
            volt_nxt = out_volt_o + mag;
         else
            volt_nxt = target_r;
      end else if ($signed(out_volt_o) - $signed(target_r) > $signed({1'b0, mag})) begin
         volt_nxt = out_volt_o - mag;
      end else begin
         volt_nxt = target_r;
      end
   end

   // Output voltage and bridge legs, all registered.
   always @(posedge clock_i) begin
      if (reset_i) begin
         out_volt_o   <= 16'h0000;
         led_color_o  <= `DCMFS_LED_OFF;
         white_high_o <= 1'b0;
         white_low_o  <= 1'b0;
         green_high_o <= 1'b0;
         green_low_o  <= 1'b0;
      end else begin
         out_volt_o  <= volt_nxt;
         led_color_o <= led_nxt;
         white_high_o <= ~shutdown & ~volt_nxt[15] & (volt_nxt != 16'h0000);
         green_low_o  <= ~shutdown & ~volt_nxt[15] & (volt_nxt != 16'h0000);
         green_high_o <= ~shutdown & volt_nxt[15];
         white_low_o  <= ~shutdown & volt_nxt[15];
      end
   end

endmodule

`default_nettype wire

// File: include/dcmfs_regs.vh
`ifndef DCMFS_REGS_VH
`define DCMFS_REGS_VH

// Register byte offsets on the AHB-Lite slave.
`define DCMFS_OFF_CTRL    12'h000
`define DCMFS_OFF_CMD     12'h004
`define DCMFS_OFF_RAMP    12'h008
`define DCMFS_OFF_IDENT   12'h00C
`define DCMFS_OFF_STATUS  12'h010
`define DCMFS_OFF_OUTV    12'h014
`define DCMFS_OFF_IRQST   12'h018
`define DCMFS_OFF_IRQMSK  12'h01C

// Status and interrupt bit positions.
`define DCMFS_B_OVERCUR   0
`define DCMFS_B_OVERTEMP  1
`define DCMFS_B_UNDERV    2
`define DCMFS_B_LIMFWD    3
`define DCMFS_B_LIMREV    4
`define DCMFS_B_LINKERR   5
`define DCMFS_B_FAULT     6
`define DCMFS_NEVT        7

// Control register: bit 0 enables the CAN command write as a valid command strobe.
`define DCMFS_B_CTRL_EN   0

// Reset values.
`define DCMFS_RST_IDENT   8'h01
`define DCMFS_RST_RAMP    16'h0000

// Timing: clock rate, fault hold and link timeout.
`define DCMFS_CLK_HZ      50000000
`define DCMFS_HOLD_S      3
`define DCMFS_HOLD_CYC    (`DCMFS_CLK_HZ * `DCMFS_HOLD_S)
`define DCMFS_LINK_MS     100
`define DCMFS_LINK_CYC    (`DCMFS_CLK_HZ / 1000 * `DCMFS_LINK_MS)
`define DCMFS_SLOW_CYC    25000000
`define DCMFS_FAST_CYC    5000000

// Indicator colour codes.
`define DCMFS_LED_OFF     2'h0
`define DCMFS_LED_GREEN   2'h1
`define DCMFS_LED_RED     2'h2
`define DCMFS_LED_YELLOW  2'h3

`endif

// File: sim/dcmfs_console.sv
`timescale 1ns/10ps
`default_nettype none
// Command source standing in for the console or a servo transmitter.
module dcmfs_console (
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic        link_i,
   input  wire logic        defer_i,
   input  wire logic [15:0] target_i,
   input  wire logic [7:0]  ident_i,
   output var  logic        valid_o,
   output wire logic [15:0] volt_o
);
   logic [15:0] sent_r;
   logic [15:0] tgt_prev_r;
   logic [7:0]  id_prev_r;
   logic        stop_r;
   // Link presence follows the bench one edge later.
   always @(posedge clock_i) begin
      valid_o <= link_i & ~reset_i;
   end
   // deferred final value; a new identifier stops the motor.
   always @(posedge clock_i) begin
      if (reset_i) begin
         sent_r     <= 16'h0000;
         tgt_prev_r <= target_i;
         id_prev_r  <= ident_i;
         stop_r     <= 1'b0;
      end else begin
         tgt_prev_r <= target_i;
         id_prev_r  <= ident_i;
         if (ident_i != id_prev_r) begin
            stop_r <= 1'b1;
            sent_r <= 16'h0000;
         end else if (stop_r && target_i == tgt_prev_r) begin
            sent_r <= 16'h0000;
         end else if (!defer_i) begin
            stop_r <= 1'b0;
            sent_r <= target_i;
         end
      end
   end
   // one selected controller receives every command.
   // A dropped link shows the inverse so that no stale value looks valid.
   assign volt_o = valid_o ? sent_r : ~sent_r;
endmodule
`default_nettype wire

// File: sim/dcmfs_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Watches fault shutdown, indicator and bridge polarity at the ports.
module dcmfs_chk (
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic        undervolt_i,
   input wire logic        overtemp_i,
   input wire logic        overcur_i,
   input wire logic        limit_fwd_i,
   input wire logic        pwm_valid_i,
   input wire logic        white_high_o,
   input wire logic        white_low_o,
   input wire logic        green_high_o,
   input wire logic        green_low_o,
   input wire logic [15:0] out_volt_o,
   input wire logic [1:0]  led_color_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   fault_stop_a: assert property ((undervolt_i || overtemp_i || overcur_i) |=>
      out_volt_o == 16'h0000 && !white_high_o && !green_high_o) else $error("drive in fault");
   limit_stop_a: assert property (limit_fwd_i && $signed(out_volt_o) > 0 |=>
      out_volt_o == 16'h0000) else $error("drive into limit");
   red_shown_a: assert property (overcur_i [*3] |->
      led_color_o == 2'h2 || led_color_o == 2'h0) else $error("fault not red");
   hold_kept_a: assert property ($fell(overcur_i) && !undervolt_i && !overtemp_i |=>
      (led_color_o != 2'h1 && led_color_o != 2'h3) [*8]) else $error("hold lost");
   link_clear_a: assert property (pwm_valid_i [*3] ##0 $past(out_volt_o) != 16'h0000 |->
      led_color_o != 2'h3) else $error("link error kept");
   pos_drive_a: assert property ($signed(out_volt_o) > 0 [*2] |->
      white_high_o && green_low_o && !white_low_o && !green_high_o) else $error("bad pos legs");
   neg_drive_a: assert property ($signed(out_volt_o) < 0 [*2] |->
      green_high_o && white_low_o && !green_low_o && !white_high_o) else $error("bad neg legs");
   fault_off_a: assert property (overtemp_i [*2] |->
      !white_high_o && !green_high_o && !white_low_o && !green_low_o) else $error("legs on");
endmodule
bind dcmfs_top dcmfs_chk chk_u (.clock_i, .reset_i, .undervolt_i, .overtemp_i, .overcur_i,
   .limit_fwd_i, .pwm_valid_i, .white_high_o, .white_low_o, .green_high_o, .green_low_o,
   .out_volt_o, .led_color_o);
`default_nettype wire

// File: sim/tb_dc_motor_fault_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dc_motor_fault_supervisor;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        hsel_i = 1'b1;
   logic [31:0] haddr_i = 32'h00000000;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [2:0]  hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h00000000;
   logic [31:0] hrdata_o;
   logic        hreadyout_o, hresp_o, pwm_valid_i, irq_o;
   logic        undervolt_i = 1'b0, overtemp_i = 1'b0, overcur_i = 1'b0;
   logic        limit_fwd_i = 1'b0, limit_rev_i = 1'b0, link_i = 1'b0, defer_i = 1'b0;
   logic [15:0] target_i = 16'h0000, pwm_volt_i, out_volt_o, v;
   logic        white_high_o, white_low_o, green_high_o, green_low_o, mon_go = 1'b0;
   logic [1:0]  led_color_o;
   logic [7:0]  ident_sel = 8'h01;
   logic [31:0] exp_v, got_v, exp_q[$];
   int          msel = 0, error_cnt = 0, samples_checked = 0, cyc_cnt = 0;

   always #10 clock_i = ~clock_i;

   dcmfs_top #(.HOLD_CYC(32'd20), .LINK_CYC(32'd10), .SLOW_CYC(32'd8), .FAST_CYC(32'd2)) dut_u (
      .clock_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
      .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .undervolt_i, .overtemp_i,
      .overcur_i, .limit_fwd_i, .limit_rev_i, .pwm_valid_i, .pwm_volt_i, .white_high_o,
      .white_low_o, .green_high_o, .green_low_o, .out_volt_o, .led_color_o, .irq_o);
   dcmfs_console con_u (.clock_i, .reset_i, .link_i, .defer_i, .target_i, .ident_i(ident_sel),
      .valid_o(pwm_valid_i), .volt_o(pwm_volt_i));

   // Oldest note is compared against the selected output when a result is due.
   always @(posedge clock_i) begin
      if (mon_go) begin
         exp_v = exp_q.pop_front();
         case (msel)
            0: got_v = hrdata_o;
            1: got_v = {16'h0000, out_volt_o};
            2: got_v = {28'h0000000, white_high_o, white_low_o, green_high_o, green_low_o};
            3: got_v = {31'h00000000, irq_o};
            5: got_v = {30'h00000000, hreadyout_o, hresp_o};
            default: got_v = {31'h00000000, $signed(out_volt_o) < 16'sh0028};
         endcase
         `CMP(got_v, exp_v)
      end
   end
   // Hang guard, well above the length of the whole sequence.
   always @(posedge clock_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 4000) begin
         error_cnt++;
         complete_run;
      end
   end

   task automatic bus(input logic w, input logic [31:0] a, d, e);
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge clock_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      if (!w) exp_q.push_back(e);
      msel <= 0;
      mon_go <= !w;
      do @(posedge clock_i); while (hreadyout_o !== 1'b1);
      mon_go <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic chk(input int s, input logic [31:0] e);
      exp_q.push_back(e);
      msel <= s;
      mon_go <= 1'b1;
      @(posedge clock_i);
      mon_go <= 1'b0;
      @(posedge clock_i);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Main sequence.
   initial begin
      void'($urandom(34996));
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      bus(0, 32'h0C, 0, 32'h1);
      bus(0, 32'h40, 0, 32'h0);
      bus(0, 32'h10, 0, 32'h20);
      chk(5, 32'h2);
      $display("reset test done");
      v = 16'($urandom_range(32'h7FFF, 1));
      link_i <= 1'b1;
      target_i <= v;
      repeat (4) @(posedge clock_i);
      chk(1, {16'h0000, v});
      chk(2, 32'h9);
      bus(0, 32'h10, 0, 32'h0);
      target_i <= -v;
      repeat (4) @(posedge clock_i);
      chk(2, 32'h6);
      target_i <= 16'h0000;
      repeat (4) @(posedge clock_i);
      bus(1, 32'h08, 32'h4, 0);
      bus(0, 32'h08, 0, 32'h4);
      target_i <= 16'h0028;
      repeat (4) @(posedge clock_i);
      chk(4, 32'h1);
      repeat (12) @(posedge clock_i);
      chk(1, 32'h28);
      $display("drive test done");
      bus(1, 32'h1C, 32'h7F, 0);
      bus(1, 32'h18, 32'h7F, 0);
      for (int b = 0; b < 3; b++) begin
         {undervolt_i, overtemp_i, overcur_i} <= 3'b001 << b;
         repeat (3) @(posedge clock_i);
         chk(1, 32'h0);
         chk(3, 32'h1);
         bus(0, 32'h10, 0, (32'h1 << b) | 32'h40);
         {undervolt_i, overtemp_i, overcur_i} <= 3'b000;
         repeat (36) @(posedge clock_i);
         bus(0, 32'h10, 0, 32'h0);
         chk(1, 32'h28);
         bus(1, 32'h18, 32'h7F, 0);
         chk(3, 32'h0);
      end
      bus(1, 32'h1C, 32'h0, 0);
      overcur_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk(3, 32'h0);
      overcur_i <= 1'b0;
      limit_rev_i <= 1'b1;
      repeat (36) @(posedge clock_i);
      chk(1, 32'h28);
      limit_rev_i <= 1'b0;
      limit_fwd_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk(1, 32'h0);
      limit_fwd_i <= 1'b0;
      bus(0, 32'h10, 0, 32'h0);
      $display("fault test done");
      defer_i <= 1'b1;
      target_i <= 16'h0010;
      repeat (20) @(posedge clock_i);
      chk(1, 32'h28);
      defer_i <= 1'b0;
      repeat (12) @(posedge clock_i);
      chk(1, 32'h10);
      ident_sel <= 8'h02;
      repeat (12) @(posedge clock_i);
      chk(1, 32'h0);
      link_i <= 1'b0;
      repeat (14) @(posedge clock_i);
      bus(0, 32'h10, 0, 32'h20);
      link_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      bus(0, 32'h10, 0, 32'h0);
      bus(1, 32'h0C, 32'h7, 0);
      bus(0, 32'h0C, 0, 32'h7);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      bus(0, 32'h0C, 0, 32'h1);
      $display("link test done");
      complete_run;
   end
endmodule
`default_nettype wire
